/* rtl/clutp_pkg.sv */
/*
  Constants for the colour table pixel pipeline control block.
  Assumes one 100 MHz system clock; host and pixel pins are asynchronous to it, while reset and video ready are synchronous.
*/
package clutp_pkg;
  // Host port locations
  localparam logic [1:0] LOC_SET   = 2'h0;
  localparam logic [1:0] LOC_INDEX = 2'h1;
  localparam logic [1:0] LOC_DATA  = 2'h2;
  // Register sets
  localparam logic [7:0] SET_RGB_WR = 8'h00;
  localparam logic [7:0] SET_RGB_RD = 8'h01;
  localparam logic [7:0] SET_PS_WR  = 8'h02;
  localparam logic [7:0] SET_PS_RD  = 8'h03;
  localparam logic [7:0] SET_OV_WR  = 8'h20;
  localparam logic [7:0] SET_OV_RD  = 8'h21;
  localparam logic [7:0] SET_PMASK  = 8'h40;
  localparam logic [7:0] SET_OMASK  = 8'h43;
  localparam logic [7:0] SET_DAC    = 8'h46;
  localparam logic [7:0] SET_MODE   = 8'h49;
  localparam logic [7:0] SET_PAN    = 8'h4A;
  localparam logic [7:0] SET_COMP   = 8'h4B;
  localparam logic [7:0] SET_CK_LO  = 8'h80;
  localparam logic [7:0] SET_CK_MID = 8'h81;
  localparam logic [7:0] SET_CK_HI  = 8'h82;
  // Reset values and fixed checksum read value
  localparam logic [7:0] PMASK_RST = 8'hFF;
  localparam logic [1:0] OMASK_RST = 2'h0;
  localparam logic [4:0] DAC_RST   = 5'h00;
  localparam logic [6:0] MODE_RST  = 7'h00;
  localparam logic [3:0] PAN_RST   = 4'h0;
  localparam logic [1:0] COMP_RST  = 2'h0;
  localparam logic [7:0] CK_RD     = 8'h00;
  // Field positions
  localparam int MODE_ACC_LSB  = 2;
  localparam int MODE_SRC_LSB  = 5;
  localparam int DAC_SYNC_BIT  = 0;
  localparam int DAC_BLANK_BIT = 1;
  localparam int DAC_RES_BIT   = 2;
  localparam int DAC_CON_LSB   = 3;
  localparam int PAN_OVL_BIT   = 3;
  // Codes
  localparam logic [1:0] SZ_32    = 2'h0;
  localparam logic [1:0] SZ_8     = 2'h1;
  localparam logic [1:0] SZ_16    = 2'h2;
  localparam logic [1:0] CON_OFF  = 2'h3;
  localparam logic [1:0] CMP_SELNZ = 2'h0;
  localparam logic [1:0] CMP_NZ    = 2'h1;
  localparam logic [1:0] CMP_SEL   = 2'h2;
  typedef enum logic [1:0] {CMP_RED, CMP_GREEN, CMP_BLUE} clutp_cmp_t;
endpackage : clutp_pkg

/* rtl/clutp_ctrl.sv */
/*
  Colour table pixel pipeline control: host port, tables, masks, modes,
  pixel serialiser, FIFO and output pipeline with panning delay.
  Assumes host strobes and pixel pins are asynchronous and slow against i_clk;
  the pixel port clock runs at most once per N+4 system cycles.
*/
// Operation
// - Red, green, blue written; index advances
// - Entries change only as whole triples
// - Reads return red, green, blue; advance
// - Pseudo address ANDed with pseudo mask
// - Overlay bits ANDed with mask substitute colour
// - Mode bits 1:0 choose pixel size
// - Mode bits 4:2 give acceleration factor
// - Mode bits 6:5 choose pseudo byte source
// - 8 bit pixels use pseudo tables
// - 16 bit pixels split, zero filled
// - 32 bit pixels choose pseudo or true
// - DAC bits 1:0 disable pedestals
// - DAC bit 2 selects 6 bit resolution
// - DAC bits 4:3 set contrast or blank
// - Pan delays sync, blank, overlays 0..7
// - Zero aligns; each step adds one pixel
// - Pan bit 3 leaves overlays undelayed
// - Single registers ignore the index
// - Checksum sets read only; gaps reserved
// - Select lines decode set, index, data
// - Select on strobe fall, write data on rise
// - Set or index write resets byte counter
// - Unused register bits read as zero
module clutp_fifo #(
  parameter int W = 37,
  parameter int D = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic      [W-1:0] o_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  logic         push;
  logic         pop;
  assign o_valid = wp_q != rp_q;
  assign o_ready = (wp_q[AW-1:0] != rp_q[AW-1:0]) || (wp_q[AW] == rp_q[AW]);
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;
  assign o_data  = mem[rp_q[AW-1:0]];
  always_ff @(posedge i_clk) begin
    if (push) mem[wp_q[AW-1:0]] <= i_data;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
endmodule : clutp_fifo
module clutp_ctrl #(
  parameter int NPIX = 5,
  parameter int FD   = 8
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Host port
  input  wire logic              i_host_wr_n,
  input  wire logic              i_host_rd_n,
  input  wire logic [1:0]        i_host_location_select,
  input  wire logic [7:0]        i_host_byte_bus,
  output logic      [7:0]        o_host_byte_bus,
  output logic                   o_host_byte_oe,
  // Pixel port
  input  wire logic              i_pixel_port_clock,
  input  wire logic [32*NPIX-1:0] i_pixel_port,
  input  wire logic [2*NPIX-1:0] i_overlay,
  input  wire logic [NPIX-1:0]   i_true_pseudo_choose,
  input  wire logic              i_hsync_n,
  input  wire logic              i_vsync_n,
  input  wire logic              i_blank_n,
  // Video output
  input  wire logic              i_video_ready,
  output logic                   o_video_valid,
  output logic      [7:0]        o_red,
  output logic      [7:0]        o_green,
  output logic      [7:0]        o_blue,
  output logic                   o_sync_cut,
  output logic                   o_blank_cut
);
  import clutp_pkg::*;
  localparam int SW = 35*NPIX + 16;
  // Pin synchroniser; only stage two is read
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  always_ff @(posedge i_clk) begin
    s1_q <= {i_host_wr_n, i_host_rd_n, i_host_location_select, i_host_byte_bus,
             i_pixel_port_clock, i_pixel_port, i_overlay, i_true_pseudo_choose,
             i_hsync_n, i_vsync_n, i_blank_n};
    s2_q <= s1_q;
  end
  logic                s_wr, s_rd, s_pclk, s_hs, s_vs, s_bl;
  logic [1:0]          s_loc;
  logic [7:0]          s_bus;
  logic [32*NPIX-1:0]  s_pix;
  logic [2*NPIX-1:0]   s_ov;
  logic [NPIX-1:0]     s_sel;
  assign {s_wr, s_rd, s_loc, s_bus, s_pclk, s_pix, s_ov, s_sel, s_hs, s_vs, s_bl} = s2_q;
  // Host strobe and pixel port clock edges
  logic wr_p_q, rd_p_q, pclk_p_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_p_q   <= 1'b1;
      rd_p_q   <= 1'b1;
      pclk_p_q <= 1'b0;
    end else begin
      wr_p_q   <= s_wr;
      rd_p_q   <= s_rd;
      pclk_p_q <= s_pclk;
    end
  end
  wire wr_fall = ~s_wr & wr_p_q;
  wire wr_rise = s_wr & ~wr_p_q;
  wire rd_fall = ~s_rd & rd_p_q;
  wire rd_rise = s_rd & ~rd_p_q;
  logic [1:0]  wloc_q, rloc_q;
  logic [7:0]  set_q, index_q, stg_r_q, stg_g_q, pmask_q;
  logic [1:0]  omask_q, comp_q;
  logic [4:0]  dac_q;
  logic [6:0]  mode_q;
  logic [3:0]  pan_q;
  clutp_cmp_t  cnt_q;
  logic [7:0]  colour_table_rgb [3][256];
  logic [7:0]  colour_table_ps  [3][256];
  logic [7:0]  colour_table_ov  [3][4];
  logic [7:0]  tri_w            [3];
  wire tbl_wr   = set_q == SET_RGB_WR || set_q == SET_PS_WR || set_q == SET_OV_WR;
  wire tbl_rd   = set_q == SET_RGB_RD || set_q == SET_PS_RD || set_q == SET_OV_RD;
  wire data_wr  = wr_rise && wloc_q == LOC_DATA;
  wire sel_wr   = wr_rise && (wloc_q == LOC_SET || wloc_q == LOC_INDEX);
  wire tbl_step = (data_wr & tbl_wr) | (rd_rise && rloc_q == LOC_DATA && tbl_rd);
  wire tbl_we   = data_wr & tbl_wr & (cnt_q == CMP_BLUE);
  assign tri_w[0] = stg_r_q;
  assign tri_w[1] = stg_g_q;
  assign tri_w[2] = s_bus;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wloc_q <= LOC_SET;
      rloc_q <= LOC_SET;
      set_q  <= SET_RGB_WR;
      index_q <= 8'h00;
      cnt_q  <= CMP_RED;
    end else begin
      if (wr_fall) wloc_q <= s_loc;
      if (rd_fall) rloc_q <= s_loc;
      if (wr_rise && wloc_q == LOC_SET) set_q <= s_bus;
      if (wr_rise && wloc_q == LOC_INDEX) index_q <= s_bus;
      else if (tbl_step && cnt_q == CMP_BLUE) index_q <= index_q + 8'h01;
      if (sel_wr) cnt_q <= CMP_RED;
      else if (tbl_step) cnt_q <= (cnt_q == CMP_BLUE) ? CMP_RED : clutp_cmp_t'(cnt_q + 2'h1);
    end
  end
  // Single-location registers ignore index_q entirely
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pmask_q <= PMASK_RST;
      omask_q <= OMASK_RST;
      dac_q   <= DAC_RST;
      mode_q  <= MODE_RST;
      pan_q   <= PAN_RST;
      comp_q  <= COMP_RST;
    end else if (data_wr) begin
      if (set_q == SET_PMASK) pmask_q <= s_bus;
      if (set_q == SET_OMASK) omask_q <= s_bus[1:0];
      if (set_q == SET_DAC) dac_q <= s_bus[4:0];
      if (set_q == SET_MODE) mode_q <= s_bus[6:0];
      if (set_q == SET_PAN) pan_q <= s_bus[3:0];
      if (set_q == SET_COMP) comp_q <= s_bus[1:0];
    end
  end
  // Staging holds red and green until blue completes the triple
  always_ff @(posedge i_clk) begin
    if (data_wr && tbl_wr && cnt_q == CMP_RED) stg_r_q <= s_bus;
    if (data_wr && tbl_wr && cnt_q == CMP_GREEN) stg_g_q <= s_bus;
    if (tbl_we) begin
      for (int c = 0; c < 3; c++) begin
        if (set_q == SET_RGB_WR) colour_table_rgb[c][index_q] <= tri_w[c];
        if (set_q == SET_PS_WR) colour_table_ps[c][index_q] <= tri_w[c];
        if (set_q == SET_OV_WR) colour_table_ov[c][index_q[1:0]] <= tri_w[c];
      end
    end
  end
  // Read data, taken at the strobe fall
  logic [7:0] reg_rd, rd_val;
  always_comb begin
    unique case (set_q)
      SET_RGB_RD: reg_rd = colour_table_rgb[cnt_q][index_q];
      SET_PS_RD:  reg_rd = colour_table_ps[cnt_q][index_q];
      SET_OV_RD:  reg_rd = colour_table_ov[cnt_q][index_q[1:0]];
      SET_PMASK:  reg_rd = pmask_q;
      SET_OMASK:  reg_rd = {6'h00, omask_q};
      SET_DAC:    reg_rd = {3'h0, dac_q};
      SET_MODE:   reg_rd = {1'h0, mode_q};
      SET_PAN:    reg_rd = {4'h0, pan_q};
      SET_COMP:   reg_rd = {6'h00, comp_q};
      SET_CK_LO, SET_CK_MID, SET_CK_HI: reg_rd = CK_RD;
      default:    reg_rd = 8'h00;
    endcase
  end
  assign rd_val = (s_loc == LOC_SET) ? set_q :
                  (s_loc == LOC_INDEX) ? index_q :
                  (s_loc == LOC_DATA) ? reg_rd : 8'h00;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_host_byte_bus <= 8'h00;
      o_host_byte_oe  <= 1'b0;
    end else if (rd_fall) begin
      o_host_byte_bus <= rd_val;
      o_host_byte_oe  <= 1'b1;
    end else if (rd_rise) begin
      o_host_byte_oe  <= 1'b0;
    end
  end
  // Serialiser: acceleration factor (1..N) pixels per rising port clock edge, lowest port first
  logic [32*NPIX-1:0] grp_q;
  logic [2*NPIX-1:0]  gov_q;
  logic [NPIX-1:0]    gsel_q;
  logic               gsync_q, gblank_q, busy_q;
  logic [2:0]         k_q;
  logic               f_in_rdy, f_val;
  logic [36:0]        f_out;
  wire [2:0] acc = mode_q[MODE_ACC_LSB +: 3];
  wire [2:0] nacc = (acc == 3'h0) ? 3'h1 :
                    (acc > 3'(NPIX)) ? 3'(NPIX) : acc;
  wire [1:0] psz = mode_q[1:0];
  wire [31:0] w32 = grp_q[k_q*32 +: 32];
  wire [31:0] w16 = {16'h0000, grp_q[k_q*16 +: 16]};
  wire [31:0] w8  = {24'h000000, grp_q[k_q*8 +: 8]};
  wire [31:0] slot = (psz == SZ_8) ? w8 : (psz == SZ_16) ? w16 : w32;
  wire        push = busy_q & f_in_rdy;
  wire [36:0] f_in = {slot, gov_q[k_q*2 +: 2], gsel_q[k_q], gsync_q, gblank_q};
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      k_q    <= 3'h0;
    end else if (s_pclk && !pclk_p_q) begin
      busy_q <= 1'b1;
      k_q    <= 3'h0;
    end else if (push) begin
      k_q    <= k_q + 3'h1;
      if (k_q == nacc - 3'h1) busy_q <= 1'b0;
    end
  end
  always_ff @(posedge i_clk) begin
    if (s_pclk && !pclk_p_q) begin
      grp_q    <= s_pix;
      gov_q    <= s_ov;
      gsel_q   <= s_sel;
      gsync_q  <= s_hs & s_vs;
      gblank_q <= s_bl;
    end
  end
  clutp_fifo #(.W(37), .D(FD)) u_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (busy_q),
    .o_ready (f_in_rdy),
    .i_data  (f_in),
    .o_valid (f_val),
    .i_ready (i_video_ready),
    .o_data  (f_out)
  );
  // Colour stage
  wire [31:0] fw    = f_out[36:5];
  wire [1:0]  fov   = f_out[4:3];
  wire        fsel  = f_out[2];
  wire        adv   = f_val & i_video_ready;
  wire [1:0]  src   = mode_q[MODE_SRC_LSB +: 2];
  wire [7:0]  pbyte = fw[src*8 +: 8];
  wire [7:0]  ps_addr = pbyte & pmask_q;
  wire        pnz   = pbyte != 8'h00;
  wire        cmp_ps = (comp_q == CMP_SELNZ) ? (fsel & pnz) :
                       (comp_q == CMP_NZ) ? pnz :
                       (comp_q == CMP_SEL) ? fsel : 1'b1;
  wire        use_ps = (psz == SZ_8) | ((psz == SZ_32) & cmp_ps);
  logic [7:0] ta [3];
  assign ta[0] = (psz == SZ_16) ? {fw[15:10], 2'h0} : fw[31:24];
  assign ta[1] = (psz == SZ_16) ? {fw[9:4], 2'h0} : fw[23:16];
  assign ta[2] = (psz == SZ_16) ? {fw[3:0], 4'h0} : fw[15:8];
  logic [7:0] col_q [3];
  logic       adv_q;
  logic [3:0] dl_q [8];
  always_ff @(posedge i_clk) begin
    if (i_rst) adv_q <= 1'b0;
    else adv_q <= adv;
    if (adv) begin
      for (int c = 0; c < 3; c++) begin
        col_q[c] <= use_ps ? colour_table_ps[c][ps_addr] : colour_table_rgb[c][ta[c]];
      end
      dl_q[0] <= {fov & omask_q, f_out[1], f_out[0]};
    end
  end
  // Delay line of {overlay, sync_n, blank_n}; tap 0 matches the colour stage
  for (genvar i = 1; i < 8; i++) begin : g_dl
    always_ff @(posedge i_clk) begin
      if (i_rst) dl_q[i] <= 4'h3;
      else if (adv_q) dl_q[i] <= dl_q[i-1];
    end
  end
  wire [3:0] tap    = dl_q[pan_q[2:0]];
  wire [1:0] ov_sel = pan_q[PAN_OVL_BIT] ? dl_q[0][3:2] : tap[3:2];
  wire [1:0] con    = dac_q[DAC_CON_LSB +: 2];
  logic [7:0] fin [3];
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      fin[c] = (ov_sel != 2'h0) ? colour_table_ov[c][ov_sel] : col_q[c];
      fin[c] = fin[c] >> con;
      if (dac_q[DAC_RES_BIT]) fin[c] = fin[c] & 8'hFC;
      if (!tap[0] || con == CON_OFF) fin[c] = 8'h00;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_video_valid <= 1'b0;
      o_red         <= 8'h00;
      o_green       <= 8'h00;
      o_blue        <= 8'h00;
      o_sync_cut    <= 1'b0;
      o_blank_cut   <= 1'b0;
    end else begin
      o_video_valid <= adv_q;
      if (adv_q) begin
        o_red       <= fin[0];
        o_green     <= fin[1];
        o_blue      <= fin[2];
        o_sync_cut  <= ~tap[1] & ~dac_q[DAC_SYNC_BIT];
        o_blank_cut <= ~tap[0] & ~dac_q[DAC_BLANK_BIT];
      end
    end
  end
  property p_wr_adv;
    @(posedge i_clk) disable iff (i_rst)
    data_wr && tbl_wr && cnt_q == CMP_BLUE |=> index_q == $past(index_q) + 8'h01 && cnt_q == CMP_RED;
  endproperty
  a_wr_adv: assert property (p_wr_adv) else $error("index not advanced");
  property p_partial;
    @(posedge i_clk) disable iff (i_rst)
    data_wr && tbl_wr && cnt_q != CMP_BLUE |=> index_q == $past(index_q);
  endproperty
  a_partial: assert property (p_partial) else $error("partial triple moved index");
  property p_rd_adv;
    @(posedge i_clk) disable iff (i_rst)
    rd_rise && rloc_q == LOC_DATA && tbl_rd && cnt_q == CMP_BLUE && !wr_rise
      |=> index_q == $past(index_q) + 8'h01;
  endproperty
  a_rd_adv: assert property (p_rd_adv) else $error("read index stuck");
  property p_cnt_rst;
    @(posedge i_clk) disable iff (i_rst) sel_wr |=> cnt_q == CMP_RED;
  endproperty
  a_cnt_rst: assert property (p_cnt_rst) else $error("counter not reset");
  property p_wloc;
    @(posedge i_clk) disable iff (i_rst) wr_fall |=> wloc_q == $past(s_loc);
  endproperty
  a_wloc: assert property (p_wloc) else $error("select not captured");
  property p_rsv_rd;
    @(posedge i_clk) disable iff (i_rst)
    rd_fall && s_loc == LOC_DATA && set_q == SET_DAC |=> o_host_byte_bus[7:5] == 3'h0;
  endproperty
  a_rsv_rd: assert property (p_rsv_rd) else $error("unused bits nonzero");
  property p_blanked;
    @(posedge i_clk) disable iff (i_rst)
    adv_q && con == CON_OFF |=> o_red == 8'h00 && o_green == 8'h00 && o_blue == 8'h00;
  endproperty
  a_blanked: assert property (p_blanked) else $error("DAC not blanked");
  property p_res6;
    @(posedge i_clk) disable iff (i_rst)
    adv_q && dac_q[DAC_RES_BIT] |=> o_red[1:0] == 2'h0 && o_blue[1:0] == 2'h0;
  endproperty
  a_res6: assert property (p_res6) else $error("low bits kept in 6 bit mode");
  sequence s_blank_in;
    adv_q && !dl_q[0][0] && pan_q[2:0] == 3'h0 && !dac_q[DAC_BLANK_BIT];
  endsequence
  property p_pan0;
    @(posedge i_clk) disable iff (i_rst) s_blank_in |=> o_blank_cut;
  endproperty
  a_pan0: assert property (p_pan0) else $error("blank not aligned");
endmodule : clutp_ctrl

/* test/clutp_far_model.sv */
/*
  Far-side model: video controller presenting pixel groups on the port
  clock, and a video sink with switchable back-pressure.
  Assumes the bench calls send_group and drains the got queue.
*/
module clutp_far_model #(
  parameter int NPIX = 5
) (
  // Clock
  input  wire logic              i_clk,
  // Pixel pins
  output logic                   o_port_clock,
  output logic [32*NPIX-1:0]     o_pixel,
  output logic [2*NPIX-1:0]      o_overlay,
  output logic                   o_hsync_n,
  // Video sink
  input  wire logic              i_valid,
  input  wire logic [7:0]        i_red,
  input  wire logic [7:0]        i_green,
  input  wire logic [7:0]        i_blue,
  input  wire logic              i_sync_cut,
  output logic                   o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        stall;
  logic [24:0] got[$];

  initial begin
    o_port_clock = 1'b0;
    o_pixel      = '0;
    o_overlay    = '0;
    o_hsync_n    = 1'b1;
    o_ready      = 1'b1;
    stall        = 1'b0;
  end

  always @(posedge i_clk) begin
    o_ready <= ~stall;
    if (i_valid === 1'b1) got.push_back({i_red, i_green, i_blue, i_sync_cut});
  end

  // Spacing well above N+4 cycles so no group is cut short
  task automatic send_group(input logic [32*NPIX-1:0] pix, input logic [2*NPIX-1:0] ov,
                            input logic hs_n);
    @(posedge i_clk);
    o_pixel   <= pix;
    o_overlay <= ov;
    o_hsync_n <= hs_n;
    @(posedge i_clk);
    o_port_clock <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_port_clock <= 1'b0;
    repeat (4) @(posedge i_clk);
    // Pixel and overlay lines past their hold time no longer show the group
    o_pixel   <= ~pix;
    o_overlay <= ~ov;
    repeat (8) @(posedge i_clk);
  endtask : send_group
endmodule : clutp_far_model

/* test/clut_pixel_pipeline_ctrl_bench.sv */
/*
  Self-checking bench: host port tasks, table and register tests,
  pixel path tests through the far-side model.
  Assumes the design package and modules are compiled first.
*/
module clut_pixel_pipeline_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import clutp_pkg::*;

  logic         clk, rst, wr_n, rd_n, pclk, hs_n, vld, sc, bc, rdy, oe;
  logic [1:0]   sel;
  logic [7:0]   wdat, rdat, red, grn, blu;
  logic [159:0] pix;
  logic [9:0]   ovl;
  logic [4:0]   psel;
  logic         vs_n, bl_n;
  logic [24:0]  gv;
  int           failures, checks_done;
  logic [7:0]   sets [5] = '{SET_OMASK, SET_DAC, SET_MODE, SET_PAN, SET_COMP};
  logic [7:0]   used [5] = '{8'h03, 8'h1F, 8'h7F, 8'h0F, 8'h03};

  clutp_ctrl #(.NPIX(5), .FD(8)) DUT (
    .i_clk(clk), .i_rst(rst), .i_host_wr_n(wr_n), .i_host_rd_n(rd_n),
    .i_host_location_select(sel), .i_host_byte_bus(wdat), .o_host_byte_bus(rdat),
    .o_host_byte_oe(oe), .i_pixel_port_clock(pclk), .i_pixel_port(pix),
    .i_overlay(ovl), .i_true_pseudo_choose(psel), .i_hsync_n(hs_n),
    .i_vsync_n(vs_n), .i_blank_n(bl_n), .i_video_ready(rdy), .o_video_valid(vld),
    .o_red(red), .o_green(grn), .o_blue(blu), .o_sync_cut(sc), .o_blank_cut(bc));

  clutp_far_model #(.NPIX(5)) far (
    .i_clk(clk), .o_port_clock(pclk), .o_pixel(pix), .o_overlay(ovl),
    .o_hsync_n(hs_n), .i_valid(vld), .i_red(red), .i_green(grn), .i_blue(blu),
    .i_sync_cut(sc), .o_ready(rdy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t byte got %h want %h", $time, g, e);
    end
  endtask : chk8

  task automatic chk1(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t flag got %b want %b", $time, g, e);
    end
  endtask : chk1

  // Strobes held 4 cycles to clear the 2-flop synchroniser
  task automatic hw(input logic [1:0] loc, input logic [7:0] d);
    @(posedge clk);
    sel  <= loc;
    wdat <= d;
    wr_n <= 1'b0;
    repeat (4) @(posedge clk);
    wr_n <= 1'b1;
    repeat (4) @(posedge clk);
    wdat <= ~d;
  endtask : hw

  task automatic hr(input logic [1:0] loc, input logic [7:0] e);
    @(posedge clk);
    sel  <= loc;
    rd_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk1(oe, 1'b1);
    chk8(rdat, e);
    rd_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : hr

  task automatic wreg(input logic [7:0] s, input logic [7:0] d);
    hw(LOC_SET, s);
    hw(LOC_DATA, d);
  endtask : wreg

  task automatic rreg(input logic [7:0] s, input logic [7:0] e);
    hw(LOC_SET, s);
    hr(LOC_DATA, e);
  endtask : rreg

  task automatic ld(input logic [7:0] s, input logic [7:0] ix, input logic [47:0] b,
                    input int n, input logic rd);
    hw(LOC_SET, s);
    hw(LOC_INDEX, ix);
    for (int k = 0; k < n; k++) begin
      if (rd) hr(LOC_DATA, b[47-8*k -: 8]);
      else hw(LOC_DATA, b[47-8*k -: 8]);
    end
  endtask : ld

  task automatic wait_got(input int n);
    for (int t = 0; t < 300 && far.got.size() < n; t++) @(posedge clk);
    chk1(far.got.size() >= n, 1'b1);
  endtask : wait_got

  task automatic px(input logic [159:0] p, input logic [9:0] ov, input logic h,
                    input logic [23:0] e, input logic s);
    logic [24:0] g;
    far.send_group(p, ov, h);
    wait_got(1);
    g = far.got.size() > 0 ? far.got.pop_front() : '0;
    chk8(g[24:17], e[23:16]);
    chk8(g[16:9], e[15:8]);
    chk8(g[8:1], e[7:0]);
    chk1(g[0], s);
  endtask : px

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    sel = 2'h0;
    wdat = 8'h00;
    psel = 5'h00;
    vs_n = 1'b1;
    bl_n = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rreg(SET_PMASK, PMASK_RST);
    for (int k = 0; k < 5; k++) begin
      rreg(sets[k], 8'h00);
      hw(LOC_SET, sets[k]);
      hw(LOC_INDEX, 8'h37);
      hw(LOC_DATA, 8'hFF);
      rreg(sets[k], used[k]);
      wreg(sets[k], 8'h00);
    end
    wreg(SET_CK_LO, 8'h5A);
    rreg(SET_CK_LO, CK_RD);
    rreg(8'h83, 8'h00);
    hr(2'h3, 8'h00);
    $display("test registers done");
    ld(SET_RGB_WR, 8'h10, 48'h9998_0000_0000, 2, 1'b0);
    hw(LOC_INDEX, 8'h10);
    ld(SET_RGB_WR, 8'h10, 48'h1122_3344_5566, 6, 1'b0);
    hw(LOC_DATA, 8'h77);
    ld(SET_RGB_RD, 8'h10, 48'h1122_3344_5566, 6, 1'b1);
    ld(SET_PS_WR, 8'h0A, 48'h7172_7381_8283, 6, 1'b0);
    ld(SET_PS_RD, 8'h0A, 48'h7172_7381_8283, 6, 1'b1);
    ld(SET_OV_WR, 8'h01, 48'hA1A2_A300_0000, 3, 1'b0);
    $display("test tables done");
    px(160'h1011_1000, 10'h1, 1'b1, 24'h115533, 1'b0);
    psel <= 5'h01;
    px(160'h1011_100B, 10'h0, 1'b1, 24'h818283, 1'b0);
    wreg(SET_MODE, 8'h20);
    px(160'h1011_0A00, 10'h0, 1'b1, 24'h717273, 1'b0);
    psel <= 5'h00;
    wreg(SET_MODE, 8'h00);
    px(160'h1011_100B, 10'h0, 1'b1, 24'h115533, 1'b0);
    wreg(SET_OMASK, 8'h01);
    px(160'h1011_1000, 10'h1, 1'b1, 24'hA1A2A3, 1'b0);
    wreg(SET_OMASK, 8'h02);
    px(160'h1011_1000, 10'h1, 1'b1, 24'h115533, 1'b0);
    wreg(SET_OMASK, 8'h00);
    px(160'h1011_1000, 10'h0, 1'b0, 24'h115533, 1'b1);
    vs_n <= 1'b0;
    px(160'h1011_1000, 10'h0, 1'b1, 24'h115533, 1'b1);
    vs_n <= 1'b1;
    wreg(SET_DAC, 8'h01);
    px(160'h1011_1000, 10'h0, 1'b0, 24'h115533, 1'b0);
    wreg(SET_DAC, 8'h08);
    px(160'h1011_1000, 10'h0, 1'b1, 24'h082A19, 1'b0);
    wreg(SET_DAC, 8'h18);
    px(160'h1011_1000, 10'h0, 1'b1, 24'h000000, 1'b0);
    wreg(SET_DAC, 8'h04);
    px(160'h1011_1000, 10'h0, 1'b1, 24'h105430, 1'b0);
    wreg(SET_DAC, 8'h00);
    bl_n <= 1'b0;
    px(160'h1011_1000, 10'h0, 1'b1, 24'h000000, 1'b0);
    chk1(bc, 1'b1);
    wreg(SET_DAC, 8'h02);
    px(160'h1011_1000, 10'h0, 1'b1, 24'h000000, 1'b0);
    chk1(bc, 1'b0);
    bl_n <= 1'b1;
    wreg(SET_DAC, 8'h00);
    wreg(SET_PAN, 8'h01);
    px(160'h1011_1000, 10'h0, 1'b1, 24'h000000, 1'b0);
    chk1(bc, 1'b1);
    wreg(SET_OMASK, 8'h01);
    px(160'h1011_1000, 10'h1, 1'b1, 24'h115533, 1'b0);
    px(160'h1011_1000, 10'h0, 1'b1, 24'hA1A2A3, 1'b0);
    wreg(SET_PAN, 8'h08);
    px(160'h1011_1000, 10'h1, 1'b1, 24'hA1A2A3, 1'b0);
    wreg(SET_PAN, 8'h00);
    wreg(SET_OMASK, 8'h00);
    wreg(SET_MODE, 8'h02);
    px(160'h1041, 10'h0, 1'b1, 24'h112233, 1'b0);
    wreg(SET_MODE, 8'h01);
    px(160'h0B, 10'h0, 1'b1, 24'h818283, 1'b0);
    wreg(SET_PMASK, 8'h0A);
    px(160'h0B, 10'h0, 1'b1, 24'h717273, 1'b0);
    wreg(SET_PMASK, 8'hFF);
    $display("test pixel modes done");
    wreg(SET_MODE, 8'h15);
    far.stall = 1'b1;
    far.send_group(160'h0B_0B0A_0B0A, 10'h0, 1'b1);
    chk1(far.got.size() == 0, 1'b1);
    far.stall = 1'b0;
    wait_got(5);
    for (int k = 0; k < 5; k++) begin
      gv = far.got.size() > 0 ? far.got.pop_front() : '0;
      chk8(gv[24:17], (k == 0 || k == 2) ? 8'h71 : 8'h81);
    end
    $display("test acceleration done");
    end_sim();
  end
endmodule : clut_pixel_pipeline_ctrl_bench
